// file: src/pmc_pkg.sv
// Purpose: constants and types for the global power mode controller
// Assumes: 10 MHz reference clock, one clock domain
// Notes:   control and status bits are plain ports, no register bus
//
// Contract
// - four global modes ranked active, alternate active, sleep, hibernate
// - in active modes each subsystem follows its own template bit
// - alternate active uses its own separate template
// - sleep disables most resources regardless of template bits
// - hibernate retains state, stops all clocks, wakes only on pin, reset pin or retention loss
// - active entered on wakeup, reset or software write; any interrupt wakes only from the active modes
// - sleep runs on slow oscillators; wakes on listed sleep sources
// - hibernate keeps retention regulator; wakes on pin, reset pin, retention loss
// - disabled subsystem gets clocks gated and analog bias turned off
// - cpu that disabled itself is re-enabled at next wakeup
// - every wakeup returns mode to active and enables the cpu
// - controller starts in active mode after boot
// - internal regulators may be disabled under external regulation
// - sleep exit waits resume time before entering active
package pmc_pkg;
   typedef enum logic [1:0] {
      PMC_ACTIVE,
      PMC_ALT_ACTIVE,
      PMC_SLEEP,
      PMC_HIBERNATE
   } pmc_mode_e;

   localparam int unsigned PMC_CLK_HZ        = 10000000;
   localparam int unsigned PMC_RESUME_NS     = 12000;
   localparam int unsigned PMC_RESUME_CYC    =
      (PMC_RESUME_NS * (PMC_CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned PMC_CNT_W         = 8;
   localparam int unsigned PMC_NUM_SUBSYS    = 8;
   localparam int unsigned PMC_CPU_BIT       = 0;
   localparam int unsigned PMC_NUM_SLP_SRC   = 9;
   localparam int unsigned PMC_NUM_HIB_SRC   = 3;
   localparam int unsigned PMC_SYNC_W        = 3;
   // sleep wake vector positions
   localparam int unsigned PMC_SLP_PIN       = 0;
   localparam int unsigned PMC_SLP_CMP       = 1;
   localparam int unsigned PMC_SLP_I2C       = 2;
   localparam int unsigned PMC_SLP_RTC       = 3;
   localparam int unsigned PMC_SLP_TWHEEL    = 4;
   localparam int unsigned PMC_SLP_XRESET    = 5;
   localparam int unsigned PMC_SLP_WDOG      = 6;
   localparam int unsigned PMC_SLP_PRECISE_POWER_ON_RESET      = 7;
   localparam int unsigned PMC_SLP_HIBRST    = 8;
endpackage

// file: src/pmc_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input asynchronous to ref_clk_i
// Notes:   first stage feeds only the second stage
module pmc_sync #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             reset_i,
   // data
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] out_d;

   // change counts once stages two and three agree
   assign out_d = (s2_q & s3_q) | (sync_o & (s2_q | s3_q));

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         sync_o <= '0;
      end else begin
         s1_q   <= async_i;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         sync_o <= out_d;
      end
   end
endmodule

// file: src/pmc_ctrl.sv
// Purpose: global power mode controller, top level
// Assumes: wake sources and reset events are asynchronous level inputs
// Notes:   mode requests are single-cycle strobes from logic on ref_clk_i
module pmc_ctrl
   import pmc_pkg::*;
#(
   parameter int unsigned NSUB = pmc_pkg::PMC_NUM_SUBSYS
) (
   // clock and reset
   input  wire logic                  ref_clk_i,
   input  wire logic                  reset_i,
   // software mode request
   input  wire logic                  mode_req_i,
   input  wire pmc_pkg::pmc_mode_e    mode_sel_i,
   // configuration templates
   input  wire logic [NSUB-1:0]       active_tmpl_i,
   input  wire logic [NSUB-1:0]       alt_tmpl_i,
   input  wire logic [NSUB-1:0]       sleep_keep_i,
   input  wire logic                  ext_reg_i,
   // wake sources
   input  wire logic                  any_irq_i,
   input  wire logic [pmc_pkg::PMC_NUM_SLP_SRC-1:0] sleep_wake_i,
   input  wire logic                  retention_loss_reset_i,
   // clocks and power outputs
   output logic [NSUB-1:0]            clk_en_o,
   output logic [NSUB-1:0]            bias_en_o,
   output logic                       fast_clk_en_o,
   output logic                       slow_osc_en_o,
   output logic                       dig_reg_en_o,
   output logic                       ana_reg_en_o,
   output logic                       retention_reg_en_o,
   // status
   output pmc_pkg::pmc_mode_e         mode_o,
   output logic                       resuming_o,
   output logic                       wake_o
);
   import pmc_pkg::*;

   logic [PMC_NUM_SLP_SRC-1:0] slp_s;
   logic                       irq_s;
   logic                       retention_loss_reset_s;
   logic                       slp_wake;
   logic                       hib_wake;
   logic                       act_wake;
   logic                       any_wake;
   logic                       in_active;
   logic                       resume_done;
   logic [NSUB-1:0]            tmpl_sel;
   logic [NSUB-1:0]            en_d;

   pmc_mode_e                  mode_q;
   pmc_mode_e                  mode_d;
   logic                       cpu_force_q;
   logic                       resume_q;
   logic [PMC_CNT_W-1:0]       rcnt_q;

   pmc_sync #(.WIDTH(PMC_NUM_SLP_SRC)) u_sync_slp (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .async_i   (sleep_wake_i),
      .sync_o    (slp_s)
   );

   pmc_sync #(.WIDTH(2)) u_sync_misc (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .async_i   ({any_irq_i, retention_loss_reset_i}),
      .sync_o    ({irq_s, retention_loss_reset_s})
   );

   // wake decoding per mode
   assign in_active = (mode_q == PMC_ACTIVE) || (mode_q == PMC_ALT_ACTIVE);
   assign act_wake  = in_active && irq_s;
   assign slp_wake  = (mode_q == PMC_SLEEP) && (|slp_s);
   assign hib_wake  = (mode_q == PMC_HIBERNATE) && (slp_s[PMC_SLP_PIN]
                      || slp_s[PMC_SLP_XRESET] || retention_loss_reset_s);
   assign any_wake  = act_wake || slp_wake || hib_wake;
   assign resume_done = resume_q && (rcnt_q == PMC_CNT_W'(PMC_RESUME_CYC - 1));

   // next mode
   always_comb begin
      mode_d = mode_q;
      if (resume_q) begin
         if (resume_done) begin
            mode_d = PMC_ACTIVE;
         end
      end else if (act_wake) begin
         mode_d = PMC_ACTIVE;
      end else if (hib_wake) begin
         mode_d = PMC_ACTIVE;
      end else if (mode_req_i && in_active) begin
         mode_d = mode_sel_i;
      end
   end

   // template selection and enable mapping
   assign tmpl_sel = (mode_d == PMC_ALT_ACTIVE) ? alt_tmpl_i : active_tmpl_i;

   always_comb begin
      en_d = '0;
      case (mode_d)
         PMC_ACTIVE, PMC_ALT_ACTIVE: begin
            en_d = tmpl_sel;
            if (cpu_force_q || any_wake) begin
               en_d[PMC_CPU_BIT] = 1'b1;
            end
         end
         PMC_SLEEP: begin
            en_d = sleep_keep_i & ~(NSUB'(1) << PMC_CPU_BIT);
         end
         default: begin
            en_d = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         mode_q      <= PMC_ACTIVE;
         cpu_force_q <= 1'b1;
         resume_q    <= 1'b0;
         rcnt_q      <= '0;
      end else begin
         mode_q <= mode_d;
         if (any_wake) begin
            cpu_force_q <= 1'b1;
         end else if (active_tmpl_i[PMC_CPU_BIT] && mode_q == PMC_ACTIVE) begin
            cpu_force_q <= 1'b0;
         end
         if (slp_wake && !resume_q) begin
            resume_q <= 1'b1;
            rcnt_q   <= '0;
         end else if (resume_done) begin
            resume_q <= 1'b0;
         end else if (resume_q) begin
            rcnt_q <= rcnt_q + PMC_CNT_W'(1);
         end
      end
   end

   // registered outputs
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         clk_en_o           <= '1;
         bias_en_o          <= '1;
         fast_clk_en_o      <= 1'b1;
         slow_osc_en_o      <= 1'b1;
         dig_reg_en_o       <= 1'b1;
         ana_reg_en_o       <= 1'b1;
         retention_reg_en_o <= 1'b1;
         mode_o             <= PMC_ACTIVE;
         resuming_o         <= 1'b0;
         wake_o             <= 1'b0;
      end else begin
         clk_en_o      <= en_d;
         bias_en_o     <= en_d;
         fast_clk_en_o <= (mode_d == PMC_ACTIVE) || (mode_d == PMC_ALT_ACTIVE);
         slow_osc_en_o <= (mode_d != PMC_HIBERNATE);
         dig_reg_en_o  <= (mode_d != PMC_HIBERNATE) && !ext_reg_i;
         ana_reg_en_o  <= (mode_d != PMC_HIBERNATE) && !ext_reg_i;
         retention_reg_en_o <= 1'b1;
         mode_o        <= mode_d;
         resuming_o    <= resume_q && !resume_done;
         wake_o        <= any_wake;
      end
   end

   // assertions
   hib_no_clk_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      mode_q == PMC_HIBERNATE && !hib_wake |=> clk_en_o == '0 && !slow_osc_en_o)
      else $error("clocks running in hibernate");
   wake_active_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (act_wake || hib_wake) && !resume_q |=> mode_q == PMC_ACTIVE)
      else $error("wakeup did not return to active");
   wake_cpu_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      any_wake && !resume_q && !slp_wake |=> clk_en_o[PMC_CPU_BIT])
      else $error("cpu not enabled on wakeup");
   sleep_resume_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $rose(resume_q) |-> ##119 mode_q == PMC_SLEEP ##1 mode_q == PMC_ACTIVE)
      else $error("sleep exit before resume time");
   resume_bound_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $rose(resume_q) |-> ##[1:130] mode_q == PMC_ACTIVE)
      else $error("sleep resume too long");
   no_hw_entry_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !mode_req_i && mode_q != PMC_SLEEP && mode_q != PMC_HIBERNATE
      |=> mode_q != PMC_SLEEP && mode_q != PMC_HIBERNATE)
      else $error("low power entered without request");
   sleep_cpu_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      mode_q == PMC_SLEEP && !resume_done |=> !clk_en_o[PMC_CPU_BIT])
      else $error("cpu clock on in sleep");
   ext_reg_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ext_reg_i |=> !dig_reg_en_o && !ana_reg_en_o)
      else $error("regulator on under external regulation");
   bias_clk_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      bias_en_o == clk_en_o)
      else $error("bias and clock enables differ");
endmodule

// file: verif/pmc_ctrl_bench.sv
// Purpose: self-checking bench for the global power mode controller
// Assumes: 10 MHz clock, reset held 16 cycles, no random stimulus
// Notes:   inputs driven at rising edge, outputs sampled at falling edge
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module pmc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import pmc_pkg::*;
   // clock and reset
   logic              ref_clk_i = 1'b0;
   logic              reset_i   = 1'b1;
   // stimulus
   logic              mode_req_i = 1'b0;
   pmc_mode_e         mode_sel_i = PMC_ACTIVE;
   logic [7:0]        active_tmpl_i = 8'h00;
   logic [7:0]        alt_tmpl_i    = 8'h3c;
   logic [7:0]        sleep_keep_i  = 8'h0b;
   logic              ext_reg_i     = 1'b0;
   logic              any_irq_i     = 1'b0;
   logic [8:0]        sleep_wake_i  = 9'h000;
   logic              retention_loss_reset_i = 1'b0;
   // observed
   logic [7:0]        clk_en_o, bias_en_o;
   logic              fast_clk_en_o, slow_osc_en_o, dig_reg_en_o, ana_reg_en_o;
   logic              retention_reg_en_o, resuming_o, wake_o;
   pmc_mode_e         mode_o;
   int                error_cnt = 0;
   int                n_checks  = 0;
   int                cycles    = 0;

   pmc_ctrl #(.NSUB(8)) i_dut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .mode_req_i(mode_req_i),
      .mode_sel_i(mode_sel_i), .active_tmpl_i(active_tmpl_i), .alt_tmpl_i(alt_tmpl_i),
      .sleep_keep_i(sleep_keep_i), .ext_reg_i(ext_reg_i), .any_irq_i(any_irq_i),
      .sleep_wake_i(sleep_wake_i), .retention_loss_reset_i(retention_loss_reset_i),
      .clk_en_o(clk_en_o), .bias_en_o(bias_en_o), .fast_clk_en_o(fast_clk_en_o),
      .slow_osc_en_o(slow_osc_en_o), .dig_reg_en_o(dig_reg_en_o),
      .ana_reg_en_o(ana_reg_en_o), .retention_reg_en_o(retention_reg_en_o),
      .mode_o(mode_o), .resuming_o(resuming_o), .wake_o(wake_o));

   always #50 ref_clk_i = ~ref_clk_i;

   // hang guard
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 6000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // one-cycle software mode request, then settle
   task automatic go(pmc_mode_e m);
      @(posedge ref_clk_i);
      mode_sel_i <= m;
      mode_req_i <= 1'b1;
      @(posedge ref_clk_i);
      mode_req_i <= 1'b0;
      repeat (2) @(negedge ref_clk_i);
   endtask

   task automatic boot_and_templates();
      repeat (2) @(negedge ref_clk_i);
      `CHK("mode", PMC_ACTIVE, mode_o)
      `CHK("clk_en", 8'h01, clk_en_o)
      `CHK("ret_reg", 1'b1, retention_reg_en_o)
      @(posedge ref_clk_i) active_tmpl_i <= 8'ha5;
      repeat (2) @(negedge ref_clk_i);
      `CHK("clk_en", 8'ha5, clk_en_o)
      @(posedge ref_clk_i) active_tmpl_i <= 8'ha4;
      repeat (2) @(negedge ref_clk_i);
      `CHK("clk_en", 8'ha4, clk_en_o)
      `CHK("bias_en", 8'ha4, bias_en_o)
      @(posedge ref_clk_i) ext_reg_i <= 1'b1;
      repeat (2) @(negedge ref_clk_i);
      `CHK("dig_reg", 1'b0, dig_reg_en_o)
      `CHK("ana_reg", 1'b0, ana_reg_en_o)
      @(posedge ref_clk_i) ext_reg_i <= 1'b0;
      repeat (2) @(negedge ref_clk_i);
      `CHK("dig_reg", 1'b1, dig_reg_en_o)
   endtask

   task automatic alt_and_irq();
      go(PMC_ALT_ACTIVE);
      `CHK("mode", PMC_ALT_ACTIVE, mode_o)
      `CHK("clk_en", 8'h3c, clk_en_o)
      `CHK("fast_clk", 1'b1, fast_clk_en_o)
      go(PMC_ACTIVE);
      `CHK("mode", PMC_ACTIVE, mode_o)
      `CHK("clk_en", 8'ha4, clk_en_o)
      go(PMC_ALT_ACTIVE);
      @(posedge ref_clk_i) any_irq_i <= 1'b1;
      repeat (8) @(negedge ref_clk_i);
      `CHK("mode", PMC_ACTIVE, mode_o)
      `CHK("clk_en", 8'ha5, clk_en_o)
      go(PMC_SLEEP);
      `CHK("mode", PMC_ACTIVE, mode_o)
      @(posedge ref_clk_i) any_irq_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
   endtask

   task automatic sleep_wake(int b);
      int   n;
      logic seen;
      go(PMC_SLEEP);
      `CHK("mode", PMC_SLEEP, mode_o)
      `CHK("clk_en", 8'h0a, clk_en_o)
      `CHK("fast_clk", 1'b0, fast_clk_en_o)
      `CHK("slow_osc", 1'b1, slow_osc_en_o)
      go(PMC_HIBERNATE);
      `CHK("mode", PMC_SLEEP, mode_o)
      @(posedge ref_clk_i) sleep_wake_i[b] <= 1'b1;
      n = 0;
      seen = 1'b0;
      while (mode_o !== PMC_ACTIVE && cycles < 6000) begin
         @(negedge ref_clk_i);
         n += int'(resuming_o);
         seen |= wake_o;
      end
      `CHK("resume", 1'b1, n >= PMC_RESUME_CYC - 1 && n <= PMC_RESUME_CYC + 1)
      `CHK("clk_en", 8'ha5, clk_en_o)
      `CHK("wake", 1'b1, seen)
      @(posedge ref_clk_i) sleep_wake_i <= 9'h000;
      repeat (8) @(posedge ref_clk_i);
   endtask

   // reset in mid-run, taken while asleep
   task automatic reset_in_sleep();
      go(PMC_SLEEP);
      `CHK("mode", PMC_SLEEP, mode_o)
      @(posedge ref_clk_i) reset_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (2) @(negedge ref_clk_i);
      `CHK("mode", PMC_ACTIVE, mode_o)
      `CHK("clk_en", 8'ha5, clk_en_o)
   endtask

   task automatic hib_wake(int b);
      int n;
      go(PMC_HIBERNATE);
      `CHK("mode", PMC_HIBERNATE, mode_o)
      `CHK("clk_en", 8'h00, clk_en_o)
      `CHK("slow_osc", 1'b0, slow_osc_en_o)
      `CHK("dig_reg", 1'b0, dig_reg_en_o)
      `CHK("ret_reg", 1'b1, retention_reg_en_o)
      @(posedge ref_clk_i) sleep_wake_i <= 9'h008;
      any_irq_i <= 1'b1;
      repeat (20) @(negedge ref_clk_i);
      `CHK("mode", PMC_HIBERNATE, mode_o)
      @(posedge ref_clk_i) sleep_wake_i <= 9'h000;
      any_irq_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      if (b == 9) retention_loss_reset_i <= 1'b1;
      else sleep_wake_i[b] <= 1'b1;
      n = 0;
      while (mode_o !== PMC_ACTIVE && n < 20) begin
         @(negedge ref_clk_i);
         n++;
      end
      `CHK("mode", PMC_ACTIVE, mode_o)
      `CHK("cpu_clk", 1'b1, clk_en_o[0])
      @(posedge ref_clk_i) sleep_wake_i <= 9'h000;
      retention_loss_reset_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      boot_and_templates();
      alt_and_irq();
      for (int b = 0; b < 9; b++) begin
         @(posedge ref_clk_i) active_tmpl_i <= 8'ha5;
         @(posedge ref_clk_i) active_tmpl_i <= 8'ha4;
         sleep_wake(b);
      end
      reset_in_sleep();
      hib_wake(0);
      hib_wake(5);
      hib_wake(9);
      test_done();
   end
endmodule
